// *** exec_tail.sv ***
// Execution tail for skip, set, subtract, swap, table read and exclusive-or
`include "exec_defs.svh"
`default_nettype none

module exec_tail
  import exec_pkg::*;
#(
  parameter int PC_WIDTH  = 12,
  parameter int ROM_WIDTH = 15
) (
  input  wire logic                  clock,
  input  wire logic                  rstn,
  input  wire logic                  issue_valid,
  output logic                       issue_ready,
  input  wire op_t                   issue_op,
  input  wire logic [7:0]            issue_addr,
  input  wire logic [2:0]            issue_bit,
  input  wire logic [7:0]            issue_imm,
  input  wire logic [7:0]            issue_mdata,
  input  wire logic [7:0]            table_pointer,
  input  wire logic [PC_WIDTH-9:0]   pc_page,
  input  wire logic [ROM_WIDTH-1:0]  rom_word,
  output logic [7:0]                 acc,
  output logic [`FLAG_WIDTH-1:0]     flags,
  output logic                       mem_we,
  output logic [7:0]                 mem_addr,
  output logic [7:0]                 mem_wdata,
  output logic                       skip_pulse,
  output logic                       rom_req,
  output logic [PC_WIDTH-1:0]        rom_addr,
  output logic [7:0]                 table_high_latch
);

  localparam int PAGE_W = PC_WIDTH - 8;

  // Table words must hold a low byte and at most a full high byte
  generate
    if (PC_WIDTH < 9 || ROM_WIDTH < 9 || ROM_WIDTH > 16) begin : g_bad
      $error("exec_tail: unsupported PC_WIDTH or ROM_WIDTH");
    end
  endgenerate

  state_t                  state_r, state_nxt;
  logic [7:0]              acc_r, acc_nxt;
  logic [`FLAG_WIDTH-1:0]  flags_r, flags_nxt;
  logic                    mem_we_r, mem_we_nxt;
  logic [7:0]              mem_addr_r, mem_addr_nxt;
  logic [7:0]              mem_wdata_r, mem_wdata_nxt;
  logic                    skip_r, skip_nxt;
  logic                    rom_req_r, rom_req_nxt;
  logic [PC_WIDTH-1:0]     rom_addr_r, rom_addr_nxt;
  logic [7:0]              table_high_latch_r, table_high_latch_nxt;

  logic                    fire;
  logic                    is_table;
  logic                    cur_bit;
  logic [7:0]              dec_val;
  logic [7:0]              inc_val;
  logic [7:0]              swp_val;
  logic [7:0]              bit_mask;
  logic [7:0]              operand;
  logic [7:0]              sub_val;
  logic                    sub_c;
  logic                    sub_ac;
  logic                    sub_ov;
  logic [7:0]              xor_val;
  logic [PAGE_W-1:0]       page_sel;
  logic [7:0]              rom_low;
  logic [7:0]              rom_high;

  // Operations whose result lands in the data byte
  function automatic logic writes_mem(input op_t op);
    return op inside {INC_SKIP_MEM, SET_BYTE, SET_BIT, SUB_MEM, SWAP_MEM, XOR_MEM};
  endfunction

  // Operations whose result lands in the accumulator
  function automatic logic writes_acc(input op_t op);
    return op inside {DEC_SKIP_ACC, INC_SKIP_ACC, SUB_ACC, SUB_IMM, SWAP_ACC,
                      COPY_SKIP_NIL, XOR_ACC, XOR_IMM};
  endfunction

  // Operations that set all four arithmetic flags
  function automatic logic is_sub(input op_t op);
    return op inside {SUB_ACC, SUB_MEM, SUB_IMM};
  endfunction

  // Operations that touch only the zero flag
  function automatic logic is_xor(input op_t op);
    return op inside {XOR_ACC, XOR_MEM, XOR_IMM};
  endfunction

  // Skip condition per operation
  function automatic logic skip_test(input op_t op, input logic [7:0] dec,
                                     input logic [7:0] inc, input logic [7:0] md,
                                     input logic bitv);
    case (op)
      DEC_SKIP_ACC:                return dec == `BYTE_ZERO;
      INC_SKIP_MEM, INC_SKIP_ACC:  return inc == `BYTE_ZERO;
      SKIP_BIT_ONE:                return bitv;
      SKIP_BYTE_NIL, COPY_SKIP_NIL: return md == `BYTE_ZERO;
      SKIP_BIT_NIL:                return !bitv;
      default:                     return 1'b0;
    endcase
  endfunction

  // Shared datapath values for the issued instruction
  assign fire     = issue_valid && issue_ready;
  assign is_table = issue_op inside {TABLE_CUR, TABLE_LAST};
  assign cur_bit  = issue_mdata[issue_bit];
  assign dec_val  = issue_mdata - `BYTE_ONE;
  assign inc_val  = issue_mdata + `BYTE_ONE;
  assign swp_val  = {issue_mdata[3:0], issue_mdata[7:4]};
  assign bit_mask = `BYTE_ONE << issue_bit;
  assign operand  = (issue_op inside {SUB_IMM, XOR_IMM}) ? issue_imm : issue_mdata;
  assign xor_val  = acc_r ^ operand;

  // subtractor shared by all three subtract forms
  alu_subtract u_sub (
    .minuend      (acc_r),
    .subtrahend   (operand),
    .diff         (sub_val),
    .carry        (sub_c),
    .nibble_carry (sub_ac),
    .signed_wrap  (sub_ov)
  );

  // The core only issues when idle; dummy and table cycles hold it off
  assign issue_ready = (state_r == ST_IDLE);

  assign skip_nxt = fire && skip_test(issue_op, dec_val, inc_val, issue_mdata, cur_bit);

  assign acc_nxt =
    !(fire && writes_acc(issue_op))                ? acc_r :
    (issue_op == DEC_SKIP_ACC)                     ? dec_val :
    (issue_op == INC_SKIP_ACC)                     ? inc_val :
    (issue_op == SWAP_ACC)                         ? swp_val :
    (issue_op == COPY_SKIP_NIL)                    ? issue_mdata :
    is_sub(issue_op)                               ? sub_val :
                                                     xor_val;

  // carry kept as no-borrow; zero flag only for xor
  assign flags_nxt =
    (fire && is_sub(issue_op)) ? {sub_ov, (sub_val == `BYTE_ZERO), sub_ac, sub_c} :
    (fire && is_xor(issue_op)) ? {flags_r[`FLAG_OV], (xor_val == `BYTE_ZERO),
                                  flags_r[`FLAG_AC], flags_r[`FLAG_C]} :
                                 flags_r;

  // table word halves, high byte zero-extended
  assign rom_low  = rom_word[7:0];
  assign rom_high = 8'(rom_word[ROM_WIDTH-1:8]);
  // last page is all ones, current page from the core
  assign page_sel = (issue_op == TABLE_LAST) ? {PAGE_W{1'b1}} : pc_page;

  // Memory write port: direct ops on issue, table low byte one cycle later
  assign mem_we_nxt   = (fire && writes_mem(issue_op)) || (state_r == ST_TABLE);
  assign mem_addr_nxt = fire ? issue_addr : mem_addr_r;
  assign mem_wdata_nxt =
    (state_r == ST_TABLE)          ? rom_low :
    !fire                          ? mem_wdata_r :
    (issue_op == INC_SKIP_MEM)     ? inc_val :
    (issue_op == SET_BYTE)         ? `BYTE_ONES :
    (issue_op == SET_BIT)          ? (issue_mdata | bit_mask) :
    (issue_op == SUB_MEM)          ? sub_val :
    (issue_op == SWAP_MEM)         ? swp_val :
    (issue_op == XOR_MEM)          ? xor_val :
                                     mem_wdata_r;

  // Program ROM request is held exactly one cycle
  assign rom_req_nxt  = fire && is_table;
  assign rom_addr_nxt = (fire && is_table) ? {page_sel, table_pointer} : rom_addr_r;
  assign table_high_latch_nxt     = (state_r == ST_TABLE) ? rom_high : table_high_latch_r;

  // dummy cycle after a taken skip; table reads take two cycles
  assign state_nxt =
    (state_r != ST_IDLE) ? ST_IDLE :
    !fire                ? ST_IDLE :
    is_table             ? ST_TABLE :
    skip_nxt             ? ST_DUMMY :
                           ST_IDLE;

  // Sequencer and result registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_r     <= ST_IDLE;
      acc_r       <= `ACC_RST;
      flags_r     <= `FLAGS_RST;
      mem_we_r    <= 1'b0;
      mem_addr_r  <= `BYTE_ZERO;
      mem_wdata_r <= `BYTE_ZERO;
      skip_r      <= 1'b0;
      rom_req_r   <= 1'b0;
      rom_addr_r  <= '0;
      table_high_latch_r      <= `TABLE_HIGH_LATCH_RST;
    end else begin
      state_r     <= state_nxt;
      acc_r       <= acc_nxt;
      flags_r     <= flags_nxt;
      mem_we_r    <= mem_we_nxt;
      mem_addr_r  <= mem_addr_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      skip_r      <= skip_nxt;
      rom_req_r   <= rom_req_nxt;
      rom_addr_r  <= rom_addr_nxt;
      table_high_latch_r      <= table_high_latch_nxt;
    end
  end

  // Outputs straight from registers
  assign acc              = acc_r;
  assign flags            = flags_r;
  assign mem_we           = mem_we_r;
  assign mem_addr         = mem_addr_r;
  assign mem_wdata        = mem_wdata_r;
  assign skip_pulse       = skip_r;
  assign rom_req          = rom_req_r;
  assign rom_addr         = rom_addr_r;
  assign table_high_latch = table_high_latch_r;

  // Checks on the execution results
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_dummy;
    skip_pulse && !issue_ready ##1 issue_ready;
  endsequence

  sequence s_table_done;
    rom_req && !issue_ready ##1 mem_we && mem_wdata == $past(rom_low)
      && table_high_latch == $past(rom_high) && issue_ready;
  endsequence

  property p_skip_two;
    fire && skip_nxt |=> s_dummy;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("skip not two cycles");

  property p_no_skip_one;
    fire && !skip_nxt && !is_table |=> !skip_pulse && issue_ready;
  endproperty
  a_no_skip_one: assert property (p_no_skip_one) else $error("plain op stalled");

  property p_dec_acc;
    fire && issue_op == DEC_SKIP_ACC |=> acc == 8'($past(issue_mdata) - 8'h01)
      && !mem_we && skip_pulse == (acc == 8'h00);
  endproperty
  a_dec_acc: assert property (p_dec_acc) else $error("decrement to acc wrong");

  property p_set_byte;
    fire && issue_op == SET_BYTE |=> mem_we && mem_wdata == 8'hFF && $stable(flags);
  endproperty
  a_set_byte: assert property (p_set_byte) else $error("byte set wrong");

  property p_set_bit;
    fire && issue_op == SET_BIT |=> mem_we
      && mem_wdata == ($past(issue_mdata) | $past(bit_mask));
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("bit set wrong");

  property p_inc_mem;
    fire && issue_op == INC_SKIP_MEM |=> mem_we
      && mem_wdata == 8'($past(issue_mdata) + 8'h01) && skip_pulse == (mem_wdata == 8'h00);
  endproperty
  a_inc_mem: assert property (p_inc_mem) else $error("increment in place wrong");

  property p_inc_acc;
    fire && issue_op == INC_SKIP_ACC |=> !mem_we
      && acc == 8'($past(issue_mdata) + 8'h01) && skip_pulse == (acc == 8'h00);
  endproperty
  a_inc_acc: assert property (p_inc_acc) else $error("increment to acc wrong");

  property p_bit_one;
    fire && issue_op == SKIP_BIT_ONE |=> skip_pulse == $past(cur_bit);
  endproperty
  a_bit_one: assert property (p_bit_one) else $error("bit one skip wrong");

  property p_sub_acc;
    fire && issue_op == SUB_ACC |=> acc == 8'($past(acc) - $past(issue_mdata))
      && flags[`FLAG_C] == ($past(acc) >= $past(issue_mdata));
  endproperty
  a_sub_acc: assert property (p_sub_acc) else $error("subtract or carry wrong");

  property p_byte_nil;
    fire && issue_op == SKIP_BYTE_NIL |=> skip_pulse == ($past(issue_mdata) == 8'h00)
      && !mem_we;
  endproperty
  a_byte_nil: assert property (p_byte_nil) else $error("byte zero skip wrong");

  property p_table;
    fire && is_table |=> s_table_done;
  endproperty
  a_table: assert property (p_table) else $error("table read wrong");

  property p_xor_flags;
    fire && issue_op == XOR_ACC |=> acc == ($past(acc) ^ $past(issue_mdata))
      && flags[`FLAG_Z] == (acc == 8'h00) && flags[`FLAG_C] == $past(flags[`FLAG_C]);
  endproperty
  a_xor_flags: assert property (p_xor_flags) else $error("xor result or flags wrong");

endmodule

`default_nettype wire

// *** exec_defs.svh ***
// Constants shared by the instruction execution tail
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// Flag bit positions inside the flag vector
`define FLAG_C      0
`define FLAG_AC     1
`define FLAG_Z      2
`define FLAG_OV     3
`define FLAG_WIDTH  4

// Reset values
`define ACC_RST     8'h00
`define FLAGS_RST   4'h0
`define TABLE_HIGH_LATCH_RST    8'h00

// Byte constants
`define BYTE_ONES   8'hFF
`define BYTE_ZERO   8'h00
`define BYTE_ONE    8'h01

// Machine cycles per instruction kind
`define CYC_PLAIN   1
`define CYC_SKIP    2
`define CYC_TABLE   2

`endif

// *** exec_pkg.sv ***
// Types for the instruction execution tail
`default_nettype none

package exec_pkg;

  // Operations handled by this block
  typedef enum logic [4:0] {
    OP_NONE          = 5'h00,
    DEC_SKIP_ACC     = 5'h01,
    INC_SKIP_MEM     = 5'h02,
    INC_SKIP_ACC     = 5'h03,
    SKIP_BIT_ONE     = 5'h04,
    SET_BYTE         = 5'h05,
    SET_BIT          = 5'h06,
    SUB_ACC          = 5'h07,
    SUB_MEM          = 5'h08,
    SUB_IMM          = 5'h09,
    SWAP_MEM         = 5'h0A,
    SWAP_ACC         = 5'h0B,
    SKIP_BYTE_NIL    = 5'h0C,
    COPY_SKIP_NIL    = 5'h0D,
    SKIP_BIT_NIL     = 5'h0E,
    TABLE_CUR        = 5'h0F,
    TABLE_LAST       = 5'h10,
    XOR_ACC          = 5'h11,
    XOR_MEM          = 5'h12,
    XOR_IMM          = 5'h13
  } op_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_DUMMY = 2'h1,
    ST_TABLE = 2'h2
  } state_t;

endpackage

`default_nettype wire

// *** alu_subtract.sv ***
// Eight-bit subtractor as accumulator plus inverted operand plus one
`default_nettype none

module alu_subtract (
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] subtrahend,
  output logic      [7:0] diff,
  output logic            carry,
  output logic            nibble_carry,
  output logic            signed_wrap
);

  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // Carry out set means no borrow happened
  assign full_sum     = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
  assign low_sum      = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
  assign diff         = full_sum[7:0];
  assign carry        = full_sum[8];
  assign nibble_carry = low_sum[4];
  // Signed wrap: operands of unlike sign and result sign differs from minuend
  assign signed_wrap  = (minuend[7] != subtrahend[7]) && (full_sum[7] != minuend[7]);

endmodule

`default_nettype wire

// *** core_mem_model.sv ***
// Data memory and program ROM model facing the execution tail
`default_nettype none

module core_mem_model #(
  parameter int PC_WIDTH  = 12,
  parameter int ROM_WIDTH = 15
) (
  input  wire logic                 clock,
  input  wire logic [7:0]           rd_addr,
  output logic      [7:0]           rd_data,
  input  wire logic                 wr_en,
  input  wire logic [7:0]           wr_addr,
  input  wire logic [7:0]           wr_data,
  input  wire logic                 rom_req,
  input  wire logic [PC_WIDTH-1:0]  rom_addr,
  output logic      [ROM_WIDTH-1:0] rom_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]           ram [256];
  logic [ROM_WIDTH-1:0] last_word = '0;
  logic [ROM_WIDTH-1:0] word;

  // Seeded contents so every byte starts distinct
  initial begin
    for (int i = 0; i < 256; i++) ram[i] = 8'(i * 7) ^ 8'hA5;
  end
  always @(posedge clock) begin
    if (wr_en) ram[wr_addr] <= wr_data;
    last_word <= rom_word;
  end
  // A write in flight is forwarded, as the core would for a back-to-back read
  assign rd_data = (wr_en && wr_addr == rd_addr) ? wr_data : ram[rd_addr];
  assign word = ROM_WIDTH'(rom_addr * 13) ^ ROM_WIDTH'(15'h2B5D);
  // Outside a request the word toggles, so a late sample cannot look right
  assign rom_word = rom_req ? word : ~last_word;
endmodule

`default_nettype wire

// *** test_mcu_instruction_execute_tail.sv ***
// Self-checking bench for the execution tail against an integer model
`include "exec_defs.svh"
`default_nettype none

module test_mcu_instruction_execute_tail
  import exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clock = 1'b0;
  logic                   rstn = 1'b0;
  logic                   issue_valid = 1'b0;
  op_t                    issue_op = OP_NONE;
  logic [7:0]             issue_addr = 8'h00;
  logic [2:0]             issue_bit = 3'h0;
  logic [7:0]             issue_imm = 8'h00;
  logic [7:0]             table_pointer = 8'h00;
  logic [3:0]             pc_page = 4'h0;
  logic [7:0]             issue_mdata;
  logic [14:0]            rom_word;
  logic                   issue_ready;
  logic [7:0]             acc;
  logic [`FLAG_WIDTH-1:0] flags;
  logic                   mem_we;
  logic [7:0]             mem_addr;
  logic [7:0]             mem_wdata;
  logic                   skip_pulse;
  logic                   rom_req;
  logic [11:0]            rom_addr;
  logic [7:0]             table_high_latch;
  int                     err_total = 0;
  int                     checked = 0;
  logic [31:0]            seed = 32'hB5AB852F;
  logic [7:0]             m_acc;
  logic [`FLAG_WIDTH-1:0] m_flags;
  logic [7:0]             m_tbh;
  logic [7:0]             bmem [256];
  op_t                    seq [14] = '{SET_BYTE, INC_SKIP_ACC, INC_SKIP_MEM, SKIP_BYTE_NIL,
    COPY_SKIP_NIL, SKIP_BIT_NIL, SKIP_BIT_ONE, SET_BIT, DEC_SKIP_ACC, SKIP_BIT_ONE, SWAP_ACC,
    SWAP_MEM, SUB_IMM, XOR_MEM};

  exec_tail #(.PC_WIDTH(12), .ROM_WIDTH(15)) u_dut (.clock(clock), .rstn(rstn),
    .issue_valid(issue_valid), .issue_ready(issue_ready), .issue_op(issue_op),
    .issue_addr(issue_addr), .issue_bit(issue_bit), .issue_imm(issue_imm),
    .issue_mdata(issue_mdata), .table_pointer(table_pointer), .pc_page(pc_page),
    .rom_word(rom_word), .acc(acc), .flags(flags), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .skip_pulse(skip_pulse), .rom_req(rom_req), .rom_addr(rom_addr),
    .table_high_latch(table_high_latch));
  core_mem_model #(.PC_WIDTH(12), .ROM_WIDTH(15)) u_mem (.clock(clock), .rd_addr(issue_addr),
    .rd_data(issue_mdata), .wr_en(mem_we), .wr_addr(mem_addr), .wr_data(mem_wdata),
    .rom_req(rom_req), .rom_addr(rom_addr), .rom_word(rom_word));

  // 40 MHz clock
  initial begin
    forever #12.5 clock = ~clock;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    issue_valid = 1'b0;
    repeat (n) @(negedge clock);
  endtask

  // Reset held three cycles; outputs checked while still in reset
  task automatic do_reset();
    rstn = 1'b0;
    issue_valid = 1'b0;
    repeat (3) @(negedge clock);
    m_acc = `ACC_RST;
    m_flags = `FLAGS_RST;
    m_tbh = `TABLE_HIGH_LATCH_RST;
    chk("acc", 12'(m_acc), 12'(acc)); // reset acc
    chk("flags", 12'(m_flags), 12'(flags)); // reset flags
    chk("ready", 12'h001, 12'(issue_ready)); // idle after reset
    chk("latch", 12'(m_tbh), 12'(table_high_latch)); // reset latch
    // Pulses left over from a cut instruction must be gone in reset
    chk("mem_we", 12'h000, 12'(mem_we)); // no stray write
    chk("skip", 12'h000, 12'(skip_pulse)); // no stray skip
    chk("rom_req", 12'h000, 12'(rom_req)); // no stray fetch
    rstn = 1'b1;
    $display("reset done");
  endtask

  // Issue one instruction, model it, compare every result port
  task automatic do_op(input op_t op, input logic [7:0] a, input logic [2:0] b,
                       input logic [7:0] im);
    logic [7:0]  md;
    logic [7:0]  w;
    logic [7:0]  o2;
    logic [8:0]  s;
    logic [11:0] ra;
    logic [14:0] rw;
    logic        we;
    logic        sk;
    logic        tb;
    int          n;
    for (n = 0; n < 8 && issue_ready !== 1'b1; n++) @(negedge clock);
    if (issue_ready !== 1'b1) begin
      err_total++;
      wrap_up();
    end
    issue_op = op;
    issue_addr = a;
    issue_bit = b;
    issue_imm = im;
    table_pointer = 8'(rnd());
    pc_page = 4'(rnd());
    issue_valid = 1'b1;
    md = bmem[a];
    w = md;
    o2 = (op == SUB_IMM || op == XOR_IMM) ? im : md;
    s = {1'b0, m_acc} + {1'b0, ~o2} + 9'h001;
    ra = {(op == TABLE_LAST) ? 4'hF : pc_page, table_pointer};
    rw = 15'(ra * 13) ^ 15'h2B5D;
    we = op inside {INC_SKIP_MEM, SET_BYTE, SET_BIT, SUB_MEM, SWAP_MEM, XOR_MEM,
                    TABLE_CUR, TABLE_LAST};
    tb = op inside {TABLE_CUR, TABLE_LAST};
    if (op inside {SUB_ACC, SUB_MEM, SUB_IMM}) begin
      m_flags[`FLAG_C] = s[8];
      m_flags[`FLAG_AC] = ({1'b0, m_acc[3:0]} + {1'b0, ~o2[3:0]} + 5'h01) > 5'h0F;
      m_flags[`FLAG_Z] = (s[7:0] == 8'h00);
      m_flags[`FLAG_OV] = (m_acc[7] != o2[7]) && (s[7] != m_acc[7]);
    end
    case (op)
      DEC_SKIP_ACC: m_acc = md - 8'h01;
      INC_SKIP_ACC: m_acc = md + 8'h01;
      COPY_SKIP_NIL: m_acc = md;
      INC_SKIP_MEM: w = md + 8'h01;
      SET_BYTE: w = 8'hFF;
      SET_BIT: w = md | (8'h01 << b);
      SWAP_MEM: w = {md[3:0], md[7:4]};
      SWAP_ACC: m_acc = {md[3:0], md[7:4]};
      XOR_MEM: w = m_acc ^ md;
      XOR_ACC, XOR_IMM: m_acc = m_acc ^ o2;
      TABLE_CUR, TABLE_LAST: w = rw[7:0];
      SUB_ACC, SUB_IMM: m_acc = s[7:0];
      SUB_MEM: w = s[7:0];
      default: ;
    endcase
    if (op inside {XOR_ACC, XOR_IMM}) m_flags[`FLAG_Z] = (m_acc == 8'h00);
    if (op == XOR_MEM) m_flags[`FLAG_Z] = (w == 8'h00);
    sk = (op inside {DEC_SKIP_ACC, INC_SKIP_ACC, COPY_SKIP_NIL} && m_acc == 8'h00)
      || (op == INC_SKIP_MEM && w == 8'h00) || (op == SKIP_BYTE_NIL && md == 8'h00)
      || (op == SKIP_BIT_ONE && md[b]) || (op == SKIP_BIT_NIL && !md[b]);
    if (we) bmem[a] = w;
    if (tb) m_tbh = {1'b0, rw[14:8]};
    @(posedge clock);
    @(negedge clock);
    chk("acc", 12'(m_acc), 12'(acc)); // acc
    chk("flags", 12'(m_flags), 12'(flags)); // flags
    chk("skip", 12'(sk), 12'(skip_pulse)); // skip
    chk("ready", 12'(!(sk || tb)), 12'(issue_ready)); // dummy cycle
    chk("rom_req", 12'(tb), 12'(rom_req)); // fetch
    chk("mem_we", 12'(we && !tb), 12'(mem_we)); // write for direct ops only
    if (we && !tb) chk("wdata", 12'(w), 12'(mem_wdata)); // data
    if (we) chk("addr", 12'(a), 12'(mem_addr)); // target byte
    if (tb) chk("rom_addr", ra, rom_addr); // page and pointer
    if (!tb) chk("latch", 12'(m_tbh), 12'(table_high_latch)); // latch kept
    if (sk || tb) begin
      // Offer a random instruction in the dummy cycle: it must be ignored
      issue_op = op_t'(5'(rnd() % 20));
      @(posedge clock);
      @(negedge clock);
      chk("mem_we", 12'(tb), 12'(mem_we)); // write in second cycle
      chk("skip", 12'h000, 12'(skip_pulse)); // single dummy
      chk("ready", 12'h001, 12'(issue_ready)); // two cycles total
      chk("acc", 12'(m_acc), 12'(acc)); // discarded instruction
      if (tb) chk("wdata", 12'(w), 12'(mem_wdata)); // low byte
      chk("latch", 12'(m_tbh), 12'(table_high_latch)); // high byte
    end
  endtask

  // Main sequence: directed walk of one byte, then random traffic
  initial begin
    logic [31:0] r;
    for (int i = 0; i < 256; i++) bmem[i] = 8'(i * 7) ^ 8'hA5;
    do_reset();
    foreach (seq[k]) do_op(seq[k], 8'h10, 3'h0, 8'h80);
    $display("directed walk done");
    for (int i = 0; i < 400; i++) begin
      r = rnd();
      do_op(op_t'(5'(r % 20)), {4'h0, r[11:8]}, r[14:12], r[23:16]);
      if (r[31:29] == 3'h0) idle(int'(r[26:25]) + 1);
      if (i == 200) do_reset();
    end
    idle(2);
    $display("random traffic done");
    wrap_up();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    wrap_up();
  end
endmodule

`default_nettype wire
